// File: core/fgs_irq_ctrl.sv
`timescale 1ns/1ps
// How it works
// RULE1: fast interrupt outranks every maskable source
// RULE2: fast accept copies pc, psw to backups
// RULE3: ordinary handler saves registers in software
// RULE4: pins and nmi filtered, sample clock selectable
// RULE5: filter rejects changes shorter than three samples
// RULE6: accepting interrupt clears global enable bit
// RULE7: handler rewrites global enable to allow nesting
// RULE8: group request is or of enabled members
// RULE9: handler reads group status to find source
// RULE10: edge, two level groups clock b; two clock a
// RULE11: edge group flag clears on write one
// RULE12: level flag follows peripheral flag clearing
// RULE13: level flag clears when enable written zero
// RULE14: slot picks one source, vector 128 to 255
// RULE15: slot type a on clock a, b on b
// RULE16: slot flags sticky, never block later requests
// RULE17: fast jump target from fast vector register
// RULE18: accept only when priority above mask level
// RULE19: edge flag clears when acceptance acknowledged
// RULE20: global enable set at reset, cleared on exception
// RULE21: edge group flag set on rise, set wins
// RULE22: inputs synchronised, output moves after three samples
module fgs_irq_ctrl #(
   parameter int NPIN = 4,
   parameter int GW   = 8,
   parameter int NSRC = 4
) (
   input  wire logic            clk,
   input  wire logic            reset_n,
   input  wire logic [7:0]      reg_addr,
   input  wire logic [31:0]     reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic      [31:0]     reg_rdata,
   input  wire logic [NPIN-1:0] irq_pin,
   input  wire logic            nmi_pin,
   input  wire logic [GW-1:0]   be_src,
   input  wire logic [GW-1:0]   bl0_src,
   input  wire logic [GW-1:0]   bl1_src,
   input  wire logic [GW-1:0]   al0_src,
   input  wire logic [GW-1:0]   al1_src,
   input  wire logic [NSRC-1:0] sci_a_src,
   input  wire logic [NSRC-1:0] sci_b_src,
   input  wire logic            cpu_ack,
   input  wire logic            cpu_rte,
   input  wire logic            exc_accept,
   input  wire logic [31:0]     cpu_pc,
   input  wire logic [31:0]     cpu_psw,
   input  wire logic            nmi_ack,
   output logic                 irq_req,
   output logic      [7:0]      irq_vec,
   output logic                 irq_fast,
   output logic      [31:0]     irq_target,
   output logic                 nmi_req
);
   localparam int NV = NPIN + fgs_pkg::NGRP + fgs_pkg::NSCI;
   localparam int IW = $clog2(NV);
   localparam int SW = $clog2(NSRC);
   localparam int GB = NPIN;
   localparam int SB = NPIN + fgs_pkg::NGRP;

   // configuration state
   logic            gie_ff, nxt_gie;
   logic [3:0]      mask_ff, nxt_mask;
   logic [1:0]      fsel_ff, nxt_fsel;
   logic            fast_en_ff, nxt_fast_en;
   logic [IW-1:0]   fast_sel_ff, nxt_fast_sel;
   logic [31:0]     fast_vec_ff, nxt_fast_vec;
   logic [GW-1:0]   be_en_ff, nxt_be_en;
   logic [GW-1:0]   lv_en_ff  [fgs_pkg::NLV];
   logic [GW-1:0]   nxt_lv_en [fgs_pkg::NLV];
   logic [SW-1:0]   sci_sel_ff  [fgs_pkg::NSCI];
   logic [SW-1:0]   nxt_sci_sel [fgs_pkg::NSCI];
   logic [6:0]      sci_vec_ff  [fgs_pkg::NSCI];
   logic [6:0]      nxt_sci_vec [fgs_pkg::NSCI];
   logic [3:0]      prio_ff  [NV];
   logic [3:0]      nxt_prio [NV];
   // event flags
   logic [NPIN:0]   filt_q, filt_prev_ff, pin_all;
   logic [NPIN-1:0] pin_ir_ff, nxt_pin_ir, pin_rise;
   logic            nmi_ff, nxt_nmi;
   logic [GW-1:0]   be_prev_ff, nxt_be_prev, be_st_ff, nxt_be_st;
   logic [GW-1:0]   be_set, be_clr, be_only;
   logic [GW-1:0]   lv_src    [fgs_pkg::NLV];
   logic [GW-1:0]   lv_st_ff  [fgs_pkg::NLV];
   logic [GW-1:0]   nxt_lv_st [fgs_pkg::NLV];
   logic [1:0]      sci_prev_ff, nxt_sci_prev, sci_pick, sci_rise, sci_tick;
   logic [1:0]      sci_st_ff, nxt_sci_st, sci_ir_ff, nxt_sci_ir;
   logic [31:0]     bpc_ff, nxt_bpc, bpsw_ff, nxt_bpsw;
   // arbitration and bus
   logic [fgs_pkg::NGRP-1:0] grp_req;
   logic [NV-1:0]   pend, acc_oh;
   logic [NPIN-1:0] acc_pin;
   logic            accept, found, fast_ok;
   logic [IW-1:0]   best, irq_idx_ff;
   logic [3:0]      best_p, irq_prio_ff;
   logic            nxt_req, nxt_fast;
   logic [7:0]      nxt_vec;
   logic [31:0]     nxt_target, rd_val, nxt_rdata;
   logic            peripheral_clock_a_en, peripheral_clock_b_en, filt_en;
   logic [7:0]      filt_div;

   fgs_rate_div #(.W(8)) u_peripheral_clock_a (
      .clk     (clk),
      .reset_n (reset_n),
      .div     (fgs_pkg::PERIPHERAL_CLOCK_A_DIV),
      .tick    (peripheral_clock_a_en)
   );
   fgs_rate_div #(.W(8)) u_peripheral_clock_b (
      .clk     (clk),
      .reset_n (reset_n),
      .div     (fgs_pkg::PERIPHERAL_CLOCK_B_DIV),
      .tick    (peripheral_clock_b_en)
   );
   fgs_rate_div #(.W(8)) u_fclk (
      .clk     (clk),
      .reset_n (reset_n),
      .div     (filt_div),
      .tick    (filt_en)
   );

   always_comb begin
      case (fsel_ff) // RULE4
         2'h0:    filt_div = fgs_pkg::FILT_DIV0;
         2'h1:    filt_div = fgs_pkg::FILT_DIV1;
         2'h2:    filt_div = fgs_pkg::FILT_DIV2;
         default: filt_div = fgs_pkg::FILT_DIV3;
      endcase
   end

   // pins in low bits, nmi on top
   assign pin_all = {nmi_pin, irq_pin};
   for (genvar gi = 0; gi <= NPIN; gi++) begin : g_filt
      fgs_noise_filter u_filt (
         .clk       (clk),
         .reset_n   (reset_n),
         .sample_en (filt_en),
         .din       (pin_all[gi]),
         .dout      (filt_q[gi])
      );
   end

   // level groups: 0,1 on clock b; 2,3 on clock a
   assign lv_src[0] = bl0_src;
   assign lv_src[1] = bl1_src;
   assign lv_src[2] = al0_src;
   assign lv_src[3] = al1_src;
   assign accept    = irq_req && cpu_ack;
   assign acc_oh    = accept ? (NV'(1) << irq_idx_ff) : '0;
   assign acc_pin   = acc_oh[NPIN-1:0];
   assign sci_tick  = {peripheral_clock_b_en, peripheral_clock_a_en}; // RULE15
   assign sci_pick  = {sci_b_src[sci_sel_ff[1]], sci_a_src[sci_sel_ff[0]]}; // RULE14
   assign pend      = {sci_ir_ff, grp_req, pin_ir_ff};

   always_comb begin
      grp_req[0] = |(be_st_ff & be_en_ff); // RULE8
      for (int k = 0; k < fgs_pkg::NLV; k++) begin
         grp_req[k+1] = |(lv_st_ff[k] & lv_en_ff[k]); // RULE8
      end
   end

   // configuration registers
   always_comb begin
      nxt_gie      = gie_ff;
      nxt_mask     = mask_ff;
      nxt_fsel     = fsel_ff;
      nxt_fast_en  = fast_en_ff;
      nxt_fast_sel = fast_sel_ff;
      nxt_fast_vec = fast_vec_ff;
      nxt_be_en    = be_en_ff;
      nxt_lv_en    = lv_en_ff;
      nxt_sci_sel  = sci_sel_ff;
      nxt_sci_vec  = sci_vec_ff;
      nxt_prio     = prio_ff;
      if (reg_wr) begin
         case (reg_addr)
            fgs_pkg::OFS_CTRL: begin
               nxt_gie  = reg_wdata[fgs_pkg::CTRL_GIE]; // RULE7
               nxt_mask = reg_wdata[fgs_pkg::CTRL_MASK +: 4];
               nxt_fsel = reg_wdata[fgs_pkg::CTRL_FSEL +: 2];
            end
            fgs_pkg::OFS_FAST_SEL: begin
               nxt_fast_sel = reg_wdata[IW-1:0];
               nxt_fast_en  = reg_wdata[fgs_pkg::FAST_EN_BIT];
            end
            fgs_pkg::OFS_FAST_VEC: nxt_fast_vec = reg_wdata;
            fgs_pkg::OFS_BE_EN:    nxt_be_en = reg_wdata[GW-1:0];
            fgs_pkg::OFS_SCIA_CFG: begin
               nxt_sci_sel[0] = reg_wdata[SW-1:0];
               nxt_sci_vec[0] = reg_wdata[fgs_pkg::SCI_VEC_LSB +: 7];
            end
            fgs_pkg::OFS_SCIB_CFG: begin
               nxt_sci_sel[1] = reg_wdata[SW-1:0];
               nxt_sci_vec[1] = reg_wdata[fgs_pkg::SCI_VEC_LSB +: 7];
            end
            default: ;
         endcase
         for (int k = 0; k < fgs_pkg::NLV; k++) begin
            if (reg_addr == fgs_pkg::OFS_LV_EN + 8'(4 * k)) nxt_lv_en[k] = reg_wdata[GW-1:0];
         end
         for (int v = 0; v < NV; v++) begin
            if (reg_addr == fgs_pkg::OFS_PRIO + 8'(4 * v)) nxt_prio[v] = reg_wdata[3:0];
         end
      end
      if (cpu_rte) nxt_gie = 1'b1;
      if (accept || exc_accept) nxt_gie = 1'b0; // RULE6 RULE20
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         gie_ff      <= fgs_pkg::GIE_RST; // RULE20
         mask_ff     <= fgs_pkg::MASK_RST;
         fsel_ff     <= fgs_pkg::FSEL_RST;
         fast_en_ff  <= 1'b0;
         fast_sel_ff <= '0;
         fast_vec_ff <= '0;
         be_en_ff    <= '0;
         lv_en_ff    <= '{default: '0};
         sci_sel_ff  <= '{default: '0};
         sci_vec_ff  <= '{default: '0};
         prio_ff     <= '{default: '0};
      end else begin
         gie_ff      <= nxt_gie;
         mask_ff     <= nxt_mask;
         fsel_ff     <= nxt_fsel;
         fast_en_ff  <= nxt_fast_en;
         fast_sel_ff <= nxt_fast_sel;
         fast_vec_ff <= nxt_fast_vec;
         be_en_ff    <= nxt_be_en;
         lv_en_ff    <= nxt_lv_en;
         sci_sel_ff  <= nxt_sci_sel;
         sci_vec_ff  <= nxt_sci_vec;
         prio_ff     <= nxt_prio;
      end
   end

   // event flags; a set beats a same-cycle clear, but an enable write of zero clears a level flag
   always_comb begin
      pin_rise     = filt_q[NPIN-1:0] & ~filt_prev_ff[NPIN-1:0];
      nxt_pin_ir   = (pin_ir_ff & ~acc_pin) | pin_rise; // RULE19
      nxt_nmi      = (nmi_ff & ~nmi_ack) | (filt_q[NPIN] & ~filt_prev_ff[NPIN]);
      be_set       = peripheral_clock_b_en ? (be_src & ~be_prev_ff) : '0; // RULE10 RULE21
      nxt_be_prev  = peripheral_clock_b_en ? be_src : be_prev_ff;
      be_clr       = (reg_wr && reg_addr == fgs_pkg::OFS_BE_CLR) ? reg_wdata[GW-1:0] : '0;
      be_only      = be_clr & ~be_set;
      nxt_be_st    = (be_st_ff & ~be_clr) | be_set; // RULE11 RULE21
      for (int k = 0; k < fgs_pkg::NLV; k++) begin
         // RULE10 RULE12 RULE13
         nxt_lv_st[k] = ((k < 2 ? peripheral_clock_b_en : peripheral_clock_a_en) ? lv_src[k] : lv_st_ff[k]) & nxt_lv_en[k];
      end
      sci_rise     = sci_tick & sci_pick & ~sci_prev_ff; // RULE15
      nxt_sci_prev = (sci_tick & sci_pick) | (~sci_tick & sci_prev_ff);
      nxt_sci_st   = sci_st_ff | sci_rise; // RULE16
      if (reg_wr && reg_addr == fgs_pkg::OFS_SCI_ST) begin
         nxt_sci_st = (sci_st_ff & ~reg_wdata[1:0]) | sci_rise;
      end
      nxt_sci_ir   = (sci_ir_ff & ~acc_oh[SB +: 2]) | sci_rise; // RULE16 RULE19
      nxt_bpc      = bpc_ff;
      nxt_bpsw     = bpsw_ff;
      if (accept && irq_fast) begin // RULE2
         nxt_bpc  = cpu_pc;
         nxt_bpsw = cpu_psw;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         filt_prev_ff <= '0;
         pin_ir_ff    <= '0;
         nmi_ff       <= 1'b0;
         be_prev_ff   <= '0;
         be_st_ff     <= '0;
         lv_st_ff     <= '{default: '0};
         sci_prev_ff  <= '0;
         sci_st_ff    <= '0;
         sci_ir_ff    <= '0;
         bpc_ff       <= '0;
         bpsw_ff      <= '0;
      end else begin
         filt_prev_ff <= filt_q;
         pin_ir_ff    <= nxt_pin_ir;
         nmi_ff       <= nxt_nmi;
         be_prev_ff   <= nxt_be_prev;
         be_st_ff     <= nxt_be_st;
         lv_st_ff     <= nxt_lv_st;
         sci_prev_ff  <= nxt_sci_prev;
         sci_st_ff    <= nxt_sci_st;
         sci_ir_ff    <= nxt_sci_ir;
         bpc_ff       <= nxt_bpc;
         bpsw_ff      <= nxt_bpsw;
      end
   end

   function automatic logic [7:0] vec_of(input logic [IW-1:0] i);
      if (int'(i) < GB) vec_of = fgs_pkg::PIN_VEC_BASE + 8'(i);
      else if (int'(i) < SB) vec_of = fgs_pkg::GRP_VEC_BASE + 8'(int'(i) - GB);
      else vec_of = {1'b1, sci_vec_ff[int'(i) - SB]}; // RULE14
   endfunction : vec_of

   // highest priority wins unless the enabled fast source is pending, lower index breaks ties
   always_comb begin
      best   = '0;
      best_p = '0;
      found  = 1'b0;
      for (int i = 0; i < NV; i++) begin
         if (pend[i] && prio_ff[i] > mask_ff && (!found || prio_ff[i] > best_p)) begin // RULE18
            found  = 1'b1;
            best   = IW'(i);
            best_p = prio_ff[i];
         end
      end
      fast_ok = fast_en_ff && int'(fast_sel_ff) < NV && gie_ff && pend[fast_sel_ff]
                && prio_ff[fast_sel_ff] > mask_ff;
      if (fast_ok) begin // RULE1
         best   = fast_sel_ff;
         best_p = prio_ff[fast_sel_ff];
         found  = 1'b1;
      end
      nxt_req    = gie_ff && !accept && found; // RULE6
      nxt_vec    = vec_of(best);
      nxt_fast   = fast_ok;
      nxt_target = fast_ok ? fast_vec_ff : '0; // RULE17
   end

   always_comb begin
      rd_val = '0;
      case (reg_addr)
         fgs_pkg::OFS_CTRL: begin
            rd_val[fgs_pkg::CTRL_GIE]       = gie_ff;
            rd_val[fgs_pkg::CTRL_MASK +: 4] = mask_ff;
            rd_val[fgs_pkg::CTRL_FSEL +: 2] = fsel_ff;
         end
         fgs_pkg::OFS_FAST_SEL: begin
            rd_val[IW-1:0]               = fast_sel_ff;
            rd_val[fgs_pkg::FAST_EN_BIT] = fast_en_ff;
         end
         fgs_pkg::OFS_FAST_VEC: rd_val = fast_vec_ff;
         fgs_pkg::OFS_BPC:      rd_val = bpc_ff;
         fgs_pkg::OFS_BPSW:     rd_val = bpsw_ff;
         fgs_pkg::OFS_PEND: begin
            rd_val[NV-1:0]                = pend;
            rd_val[fgs_pkg::PEND_NMI_BIT] = nmi_ff;
         end
         fgs_pkg::OFS_BE_ST:    rd_val[GW-1:0] = be_st_ff; // RULE9
         fgs_pkg::OFS_BE_EN:    rd_val[GW-1:0] = be_en_ff;
         fgs_pkg::OFS_SCIA_CFG: begin
            rd_val[SW-1:0]                     = sci_sel_ff[0];
            rd_val[fgs_pkg::SCI_VEC_LSB +: 7] = sci_vec_ff[0];
         end
         fgs_pkg::OFS_SCIB_CFG: begin
            rd_val[SW-1:0]                     = sci_sel_ff[1];
            rd_val[fgs_pkg::SCI_VEC_LSB +: 7] = sci_vec_ff[1];
         end
         fgs_pkg::OFS_SCI_ST:   rd_val[1:0] = sci_st_ff;
         default: ;
      endcase
      for (int k = 0; k < fgs_pkg::NLV; k++) begin
         if (reg_addr == fgs_pkg::OFS_LV_EN + 8'(4 * k)) rd_val[GW-1:0] = lv_en_ff[k];
         if (reg_addr == fgs_pkg::OFS_LV_ST + 8'(4 * k)) rd_val[GW-1:0] = lv_st_ff[k]; // RULE9
      end
      for (int v = 0; v < NV; v++) begin
         if (reg_addr == fgs_pkg::OFS_PRIO + 8'(4 * v)) rd_val[3:0] = prio_ff[v];
      end
      nxt_rdata = reg_rd ? rd_val : '0;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_req     <= 1'b0;
         irq_vec     <= '0;
         irq_fast    <= 1'b0;
         irq_target  <= '0;
         irq_idx_ff  <= '0;
         irq_prio_ff <= '0;
         nmi_req     <= 1'b0;
         reg_rdata   <= '0;
      end else begin
         irq_req     <= nxt_req;
         irq_vec     <= nxt_vec;
         irq_fast    <= nxt_fast;
         irq_target  <= nxt_target;
         irq_idx_ff  <= best;
         irq_prio_ff <= best_p;
         nmi_req     <= nxt_nmi;
         reg_rdata   <= nxt_rdata;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_take;
      irq_req && cpu_ack;
   endsequence

   fast_first_a: assert property ( // RULE1
      fast_ok && !accept |=> irq_fast && irq_idx_ff == $past(fast_sel_ff))
      else $error("fast request not given precedence");
   backup_copy_a: assert property ( // RULE2
      s_take ##0 irq_fast |=> bpc_ff == $past(cpu_pc) && bpsw_ff == $past(cpu_psw))
      else $error("fast accept did not copy pc and psw");
   gie_take_a: assert property (s_take |=> !gie_ff && !irq_req) // RULE6
      else $error("global enable still set after accept");
   gie_reset_a: assert property ($rose(reset_n) |-> gie_ff && !irq_req) // RULE20
      else $error("global enable not set after reset");
   gie_exc_a: assert property (exc_accept |=> !gie_ff) // RULE20
      else $error("exception did not clear global enable");
   prio_gate_a: assert property (irq_req |-> irq_prio_ff > $past(mask_ff)) // RULE18
      else $error("request raised at or below mask level");
   edge_ack_a: assert property ( // RULE19
      s_take ##0 ((acc_pin & pin_rise) == '0) |=> (pin_ir_ff & $past(acc_pin)) == '0)
      else $error("pin flag kept after acceptance");
   be_set_wins_a: assert property ( // RULE21
      be_set != '0 |=> (be_st_ff & $past(be_set)) == $past(be_set))
      else $error("edge group set lost");
   be_clear_a: assert property (be_only != '0 |=> (be_st_ff & $past(be_only)) == '0) // RULE11
      else $error("edge group flag not cleared by write");
   lvl_en_clr_a: assert property ( // RULE13
      reg_wr && reg_addr == fgs_pkg::OFS_LV_EN && reg_wdata[GW-1:0] == '0
      |=> lv_st_ff[0] == '0)
      else $error("level flag survived enable cleared");
   sci_keep_a: assert property ( // RULE16
      !(reg_wr && reg_addr == fgs_pkg::OFS_SCI_ST)
      |=> (sci_st_ff & $past(sci_st_ff)) == $past(sci_st_ff))
      else $error("slot flag cleared itself");
   sci_range_a: assert property (irq_req && int'(irq_idx_ff) >= SB |-> irq_vec[7]) // RULE14
      else $error("slot vector below 128");
endmodule : fgs_irq_ctrl

// File: core/fgs_noise_filter.sv
`timescale 1ns/1ps
module fgs_noise_filter (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic sample_en,
   input  wire logic din,
   output logic      dout
);
   logic       sync1_ff;
   logic       sync2_ff;
   logic [2:0] samp_ff;
   logic [2:0] nxt_samp;
   logic       nxt_dout;
   logic       match;

   always_comb begin
      nxt_samp = sample_en ? {samp_ff[1:0], sync2_ff} : samp_ff;  // RULE22
      match    = (samp_ff == 3'h7) || (samp_ff == 3'h0);
      nxt_dout = match ? samp_ff[0] : dout;                       // RULE5
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         samp_ff  <= 3'h0;
         dout     <= 1'b0;
      end else begin
         sync1_ff <= din;
         sync2_ff <= sync1_ff;
         samp_ff  <= nxt_samp;
         dout     <= nxt_dout;
      end
   end

   filt_three_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
      $changed(dout) |-> $past(samp_ff) == {3{dout}})
      else $error("filter output moved without three equal samples");
   filt_shift_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE22
      sample_en |=> samp_ff[0] == $past(sync2_ff))
      else $error("filter sample not taken from synchroniser");
endmodule : fgs_noise_filter

// File: core/fgs_pkg.sv
package fgs_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_FAST_SEL = 8'h04;
   localparam logic [7:0] OFS_FAST_VEC = 8'h08;
   localparam logic [7:0] OFS_BPC      = 8'h0C;
   localparam logic [7:0] OFS_BPSW     = 8'h10;
   localparam logic [7:0] OFS_PEND     = 8'h14;
   localparam logic [7:0] OFS_BE_ST    = 8'h18;
   localparam logic [7:0] OFS_BE_CLR   = 8'h1C;
   localparam logic [7:0] OFS_BE_EN    = 8'h20;
   localparam logic [7:0] OFS_LV_EN    = 8'h24;
   localparam logic [7:0] OFS_LV_ST    = 8'h34;
   localparam logic [7:0] OFS_SCIA_CFG = 8'h44;
   localparam logic [7:0] OFS_SCIB_CFG = 8'h48;
   localparam logic [7:0] OFS_SCI_ST   = 8'h4C;
   localparam logic [7:0] OFS_PRIO     = 8'h80;
   // field positions
   localparam int CTRL_GIE     = 0;
   localparam int CTRL_MASK    = 4;
   localparam int CTRL_FSEL    = 8;
   localparam int FAST_EN_BIT  = 8;
   localparam int SCI_VEC_LSB  = 8;
   localparam int PEND_NMI_BIT = 31;
   // reset values
   localparam logic       GIE_RST  = 1'b1;
   localparam logic [3:0] MASK_RST = 4'h0;
   localparam logic [1:0] FSEL_RST = 2'h0;
   // rates in clk cycles per enable pulse
   localparam logic [7:0] PERIPHERAL_CLOCK_A_DIV = 8'h02;
   localparam logic [7:0] PERIPHERAL_CLOCK_B_DIV = 8'h04;
   localparam logic [7:0] FILT_DIV0 = 8'h01;
   localparam logic [7:0] FILT_DIV1 = 8'h04;
   localparam logic [7:0] FILT_DIV2 = 8'h10;
   localparam logic [7:0] FILT_DIV3 = 8'h40;
   // vector layout
   localparam int         NGRP         = 5;
   localparam int         NSCI         = 2;
   localparam int         NLV          = 4;
   localparam logic [7:0] PIN_VEC_BASE = 8'h40;
   localparam logic [7:0] GRP_VEC_BASE = 8'h70;
endpackage : fgs_pkg

// File: core/fgs_rate_div.sv
`timescale 1ns/1ps
module fgs_rate_div #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] div,
   output logic              tick
);
   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;
   logic         nxt_tick;
   logic         last;

   // div of 0 or 1 gives a pulse every cycle
   always_comb begin
      last     = (div <= W'(1)) || (cnt_ff >= div - W'(1));
      nxt_cnt  = last ? '0 : cnt_ff + W'(1);
      nxt_tick = last;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_ff <= '0;
         tick   <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         tick   <= nxt_tick;
      end
   end
endmodule : fgs_rate_div

// File: tb/fast_group_select_irq_ctrl_test.sv
`timescale 1ns/1ps
module fast_group_select_irq_ctrl_test;
   logic        clk = 0, reset_n = 0, wr = 0, rd = 0, nmi = 0, nmi_ack = 0, exc = 0;
   logic [7:0]  addr = 8'h00, be = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rv, tgt;
   logic [3:0]  pin = 4'h0, lat = 4'h0;
   logic [7:0]  lv [4] = '{default: 8'h00};
   logic [3:0]  sci [2] = '{default: 4'h0};
   logic        irq_req, irq_fast, nmi_req, cpu_ack, cpu_rte;
   logic [7:0]  vec;
   int          bad_count = 0, samples_checked = 0, cyc = 0, i, n;
   localparam logic [31:0] PC = 32'hA5A5_0010, PSW = 32'h0000_0F0F;

   always #5 clk = ~clk;

   fgs_irq_ctrl uut (.clk(clk), .reset_n(reset_n), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .irq_pin(pin), .nmi_pin(nmi),
      .be_src(be), .bl0_src(lv[0]), .bl1_src(lv[1]), .al0_src(lv[2]), .al1_src(lv[3]),
      .sci_a_src(sci[0]), .sci_b_src(sci[1]), .cpu_ack(cpu_ack), .cpu_rte(cpu_rte),
      .exc_accept(exc), .cpu_pc(PC), .cpu_psw(PSW), .nmi_ack(nmi_ack), .irq_req(irq_req),
      .irq_vec(vec), .irq_fast(irq_fast), .irq_target(tgt), .nmi_req(nmi_req));

   fgs_cpu_model cpu (.clk(clk), .reset_n(reset_n), .irq_req(irq_req), .lat(lat),
      .cpu_ack(cpu_ack), .cpu_rte(cpu_rte));

   task automatic print_verdict;
      $display("checks=%0d errors=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge clk) wr <= 1'b0;
   endtask : wreg

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk) {addr, rd} <= {a, 1'b1};
      @(posedge clk) rd <= 1'b0;
      #1 rv = rdata;
      chk(rv, e);
   endtask : rchk

   // wait for a request, check it, then let the cpu model take it
   task automatic wait_req(input logic [7:0] v, input logic f, input logic [31:0] t);
      int k;
      k = 0;
      @(posedge clk) #1;
      while (irq_req !== 1'b1 && k < 400) begin
         @(posedge clk) #1;
         k++;
      end
      chk(32'(irq_req), 32'h1);
      chk(32'(vec), 32'(v));
      chk(32'(irq_fast), 32'(f));
      chk(tgt, t);
      k = 0;
      while (cpu_ack !== 1'b1 && k < 40) begin
         @(posedge clk) #1;
         k++;
      end
      @(posedge clk) #1;
   endtask : wait_req

   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      rchk(8'h00, 32'h1);
      rchk(8'hFC, 32'h0);
      @(posedge clk) exc <= 1'b1;
      @(posedge clk) exc <= 1'b0;
      rchk(8'h00, 32'h0);
      wreg(8'h00, 32'h1);
      wreg(8'h80, 32'h5);
      wreg(8'h84, 32'hF);
      pin[0] <= 1'b1;
      repeat (2) @(posedge clk);
      pin[0] <= 1'b0;
      repeat (20) @(posedge clk);
      rchk(8'h14, 32'h0);
      wreg(8'h00, 32'h51);
      pin[0] <= 1'b1;
      repeat (30) @(posedge clk);
      rchk(8'h14, 32'h1);
      chk(32'(irq_req), 32'h0);
      wreg(8'h00, 32'h41);
      wait_req(8'h40, 1'b0, 32'h0);
      rchk(8'h00, 32'h40);
      repeat (25) @(posedge clk);
      rchk(8'h00, 32'h41);
      rchk(8'h14, 32'h0);
      wreg(8'h04, 32'h100);
      wreg(8'h08, 32'h1230);
      pin <= 4'h0;
      repeat (10) @(posedge clk);
      pin <= 4'h3;
      wait_req(8'h40, 1'b1, 32'h1230);
      rchk(8'h0C, PC);
      rchk(8'h10, PSW);
      wreg(8'h04, 32'h0);
      wait_req(8'h41, 1'b0, 32'h0);
      pin <= 4'h0;
      wreg(8'h00, 32'h1);
      lat <= 4'h6;
      wreg(8'h20, 32'h4);
      wreg(8'h90, 32'h3);
      be[2] <= 1'b1;
      repeat (8) @(posedge clk);
      be[2] <= 1'b0;
      wait_req(8'h70, 1'b0, 32'h0);
      rchk(8'h18, 32'h4);
      wreg(8'h1C, 32'h4);
      rchk(8'h18, 32'h0);
      repeat (25) @(posedge clk);
      for (i = 0; i < 4; i++) begin
         wreg(8'h24 + 8'(4 * i), 32'h1);
         lv[i][0] <= 1'b1;
         repeat (12) @(posedge clk);
         rchk(8'h34 + 8'(4 * i), 32'h1);
         rchk(8'h14, 32'h20 << i);
         lv[i][0] <= 1'b0;
         repeat (12) @(posedge clk);
         rchk(8'h34 + 8'(4 * i), 32'h0);
         lv[i][0] <= 1'b1;
         repeat (12) @(posedge clk);
         wreg(8'h24 + 8'(4 * i), 32'h0);
         rchk(8'h34 + 8'(4 * i), 32'h0);
         lv[i][0] <= 1'b0;
      end
      for (i = 0; i < 2; i++) begin
         wreg(8'h44 + 8'(4 * i), (i == 1) ? 32'h7F01 : 32'h1);
         wreg(8'hA4 + 8'(4 * i), 32'h2);
         repeat (2) begin
            sci[i][1] <= 1'b1;
            repeat (8) @(posedge clk);
            sci[i][1] <= 1'b0;
            wait_req((i == 1) ? 8'hFF : 8'h80, 1'b0, 32'h0);
            repeat (25) @(posedge clk);
            rchk(8'h4C, 32'h1 << i);
         end
         wreg(8'h4C, 32'h1 << i);
      end
      // slower filter clock: six cycles is at most two samples
      wreg(8'h00, 32'h101);
      nmi <= 1'b1;
      repeat (6) @(posedge clk);
      nmi <= 1'b0;
      repeat (30) @(posedge clk);
      #1 chk(32'(nmi_req), 32'h0);
      @(posedge clk) nmi <= 1'b1;
      repeat (20) @(posedge clk);
      nmi <= 1'b0;
      n = 0;
      while (nmi_req !== 1'b1 && n < 50) begin
         @(posedge clk) #1;
         n++;
      end
      chk(32'(nmi_req), 32'h1);
      @(posedge clk) nmi_ack <= 1'b1;
      @(posedge clk) nmi_ack <= 1'b0;
      #1 chk(32'(nmi_req), 32'h0);
      print_verdict();
   end
endmodule : fast_group_select_irq_ctrl_test

// File: tb/fgs_cpu_model.sv
`timescale 1ns/1ps
module fgs_cpu_model (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       irq_req,
   input  wire logic [3:0] lat,
   output logic            cpu_ack,
   output logic            cpu_rte
);
   logic [3:0] cnt_ff;
   logic [4:0] ret_ff;
   // accept after lat cycles, return from handler 20 cycles later
   always_ff @(posedge clk) begin
      cpu_ack <= 1'b0;
      cpu_rte <= 1'b0;
      if (!reset_n) begin
         cnt_ff <= 4'h0;
         ret_ff <= 5'h00;
      end else begin
         cnt_ff <= 4'h0;
         if (irq_req && !cpu_ack) begin
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == lat) begin
               cpu_ack <= 1'b1;
               cnt_ff  <= 4'h0;
               ret_ff  <= 5'h01;
            end
         end
         if (ret_ff != 5'h00) begin
            ret_ff <= ret_ff + 5'h01;
            if (ret_ff == 5'h14) begin
               cpu_rte <= 1'b1;
               ret_ff  <= 5'h00;
            end
         end
      end
   end
endmodule : fgs_cpu_model
